/* hdl/abr_pkg.sv */
// Constants, types and register map for the answer-back trigger and reset block
package abr_pkg;
	// Clock rate
	localparam longint unsigned CLK_HZ         = 64'd200_000_000;
	// Power-on reset hold time, milliseconds
	localparam longint unsigned POR_TIME_MS    = 64'd200;
	localparam longint unsigned POR_CYC        = (POR_TIME_MS * CLK_HZ) / 64'd1000;
	// No-carrier timer, seconds (nominal)
	localparam longint unsigned NOCARR_TIME_S  = 64'd25;
	localparam longint unsigned NOCARR_CYC     = NOCARR_TIME_S * CLK_HZ;

	// Register bus geometry
	localparam int              ADDR_W         = 4;
	localparam int              DATA_W         = 32;
	// Register byte offsets
	localparam logic [3:0]      OFS_CTRL       = 4'h0;
	localparam logic [3:0]      OFS_STAT       = 4'h4;
	localparam logic [3:0]      OFS_IRQ_ST     = 4'h8;
	localparam logic [3:0]      OFS_IRQ_MSK    = 4'hC;

	// Control register fields
	localparam int              CTRL_PAPER_OPT = 0;
	localparam logic            CTRL_RST_PAPER = 1'b0;

	// Status register fields
	localparam int              STAT_TRIP      = 0;
	localparam int              STAT_ARMED     = 1;
	localparam int              STAT_ANS_MODE  = 2;
	localparam int              STAT_ONLINE    = 3;
	localparam int              STAT_CARRIER   = 4;
	localparam int              STAT_RESET_N   = 5;
	localparam int              STAT_EXPIRED   = 6;
	localparam int              STAT_ALARM     = 7;

	// Interrupt event bits
	localparam int              IRQ_W          = 5;
	localparam int              EV_TRIP_ON     = 0;
	localparam int              EV_TRIP_OFF    = 1;
	localparam int              EV_RESET       = 2;
	localparam int              EV_EXPIRE      = 3;
	localparam int              EV_ALARM       = 4;
	localparam logic [4:0]      IRQ_MSK_RST    = 5'h00;

	// Send-data level that means mark
	localparam logic            MARK_LVL       = 1'b1;
	// Synchroniser depth for pin inputs
	localparam int              SYNC_D         = 3;
	localparam int              PIN_N          = 10;

	// Pin inputs, all from outside the clock domain
	typedef struct packed {
		logic carrier_det;
		logic send_data;
		logic on_line;
		logic ans_btn;
		logic orig_btn;
		logic clear_btn;
		logic local_btn;
		logic eot_contact;
		logic paper_alarm;
		logic manual_answerback_key;
	} abr_pins_t;

	// Pin levels held through reset; send data rests at mark
	localparam abr_pins_t PIN_RST = '{send_data: MARK_LVL, default: 1'b0};

	// Register bus request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} abr_req_t;

	// Answer-back trigger states, one-hot
	typedef enum logic [2:0] {
		AB_ARMED = 3'b001,
		AB_TRIP  = 3'b010,
		AB_SPENT = 3'b100
	} abr_ab_state_t;
endpackage : abr_pkg

/* hdl/abr_answerback_reset.sv */
// Answer-back trigger, originate/answer state and shared reset generator
//
// Operation
// [RULE1] No carrier or not answering: trip held off
// [RULE2] Carrier, answer mode, on-line, armed: trip
// [RULE3] First space-to-mark on send data ends trip
// [RULE4] Stays cleared until carrier or condition drops
// [RULE5] Power-up holds reset about 200 ms
// [RULE6] End-of-transmission or clear button asserts reset
// [RULE7] Local button also asserts reset
// [RULE8] Paper alarm resets unless option fitted; lamp
// [RULE9] Option fitted: alarm only lights the lamp
// [RULE10] On-line starts 25 s timer; no carrier resets
// [RULE11] After expiry, carrier loss also resets
// [RULE12] Off-line disables and clears the timer
// [RULE13] Shared reset forces answer mode
// [RULE14] Pins synchronised; edge found from samples
//
// The plain strobed port and the register offsets were chosen for this implementation.
module abr_answerback_reset
	import abr_pkg::*;
#(
	parameter longint unsigned POR_CYCLES    = POR_CYC,
	parameter longint unsigned NOCARR_CYCLES = NOCARR_CYC,
	parameter int              CNT_W         = 33
)
(
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire abr_pins_t        pins_i,
	input  wire abr_req_t         req_i,
	output logic [DATA_W-1:0]     rdata_o,
	output logic                  trip_o,
	output logic                  answerback_start_o,
	output logic                  ans_mode_o,
	output logic                  orig_mode_o,
	output logic                  ctl_reset_n_o,
	output logic                  alarm_lamp_o,
	output logic                  irq_o
);

	// Internal reset, released through two flops
	logic                 rst_s1_ff;
	logic                 rst_s2_ff;
	logic                 rst_int_n;

	// Reset release synchroniser
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end
		else
		begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	assign rst_int_n = rst_s2_ff;

	// Pin synchroniser chain and filtered levels
	logic [PIN_N-1:0]     pin_raw;
	logic [PIN_N-1:0]     sy1_ff;
	logic [PIN_N-1:0]     sy2_ff;
	logic [PIN_N-1:0]     sy3_ff;
	logic [PIN_N-1:0]     pin_ff;
	abr_pins_t            pin;

	assign pin_raw = pins_i;
	assign pin     = pin_ff;

	// Three flops per pin; level accepted once 2nd and 3rd agree
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++)
		begin : g_sync
			always_ff @(posedge sys_clk or negedge rst_int_n)
			begin
				if (!rst_int_n)
				begin
					// Idle levels, so no false send-data edge follows reset
					sy1_ff[gi] <= PIN_RST[gi];
					sy2_ff[gi] <= PIN_RST[gi];
					sy3_ff[gi] <= PIN_RST[gi];
					pin_ff[gi] <= PIN_RST[gi];
				end
				else if (clk_en)
				begin
					sy1_ff[gi] <= pin_raw[gi];
					sy2_ff[gi] <= sy1_ff[gi];
					sy3_ff[gi] <= sy2_ff[gi];
					// Disagreement means a change still settling
					if (sy2_ff[gi] == sy3_ff[gi])
					begin
						pin_ff[gi] <= sy3_ff[gi]; // [RULE14]
					end
				end
			end
		end
	endgenerate

	// Previous send-data level for edge detection
	logic                 send_prev_ff;
	logic                 space_to_mark;

	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			send_prev_ff <= MARK_LVL;
		end
		else if (clk_en)
		begin
			send_prev_ff <= pin.send_data;
		end
	end

	// Edge taken from filtered samples only
	assign space_to_mark = (pin.send_data == MARK_LVL) && (send_prev_ff != MARK_LVL); // [RULE14]

	// Register file state
	logic                 paper_opt_ff;
	logic [IRQ_W-1:0]     irq_st_ff;
	logic [IRQ_W-1:0]     irq_msk_ff;
	logic [IRQ_W-1:0]     ev;
	logic [DATA_W-1:0]    nxt_rdata;
	logic [DATA_W-1:0]    stat_word;

	// Power-on reset counter
	logic [31:0]          por_cnt_ff;
	logic                 por_done_ff;

	// Hold reset until the power-up interval has elapsed
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			por_cnt_ff  <= 32'h0000_0000;
			por_done_ff <= 1'b0;
		end
		else if (clk_en && !por_done_ff)
		begin
			if (por_cnt_ff == 32'(POR_CYCLES - 64'd1))
			begin
				por_done_ff <= 1'b1; // [RULE5]
			end
			por_cnt_ff <= por_cnt_ff + 32'h0000_0001;
		end
	end

	// No-carrier timer
	logic [CNT_W-1:0]     nc_cnt_ff;
	logic                 expired_ff;
	logic                 timeout_rst;

	// Counts only while on-line; off-line clears everything
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			nc_cnt_ff  <= '0;
			expired_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!pin.on_line)
			begin
				nc_cnt_ff  <= '0; // [RULE12]
				expired_ff <= 1'b0; // [RULE12]
			end
			else if (!expired_ff)
			begin
				// Timer started by going on-line
				if (nc_cnt_ff == CNT_W'(NOCARR_CYCLES - 64'd1))
				begin
					expired_ff <= 1'b1; // [RULE10]
				end
				nc_cnt_ff <= nc_cnt_ff + CNT_W'(1);
			end
		end
	end

	// Expired and no carrier: reset now and on any later loss
	assign timeout_rst = pin.on_line && expired_ff && !pin.carrier_det; // [RULE10] [RULE11]

	// Combined reset sources, wired-OR in the original sense
	logic                 alarm_rst;
	logic                 ctl_rst;

	// Option fitted masks the alarm from the reset path
	assign alarm_rst = pin.paper_alarm && !paper_opt_ff; // [RULE8] [RULE9]
	assign ctl_rst   = !por_done_ff       // [RULE5]
		|| pin.eot_contact || pin.clear_btn // [RULE6]
		|| pin.local_btn                    // [RULE7]
		|| alarm_rst                        // [RULE8]
		|| timeout_rst;                     // [RULE10]

	// Registered shared reset and alarm lamp
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			ctl_reset_n_o <= 1'b0;
			alarm_lamp_o  <= 1'b0;
		end
		else if (clk_en)
		begin
			ctl_reset_n_o <= !ctl_rst; // [RULE6]
			// Lamp lights in either configuration
			alarm_lamp_o  <= pin.paper_alarm; // [RULE8] [RULE9]
		end
	end

	// Originate/answer state, high means originate
	logic                 orig_ff;

	// Reset has priority over both buttons
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			orig_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			if (ctl_rst || pin.ans_btn)
			begin
				orig_ff <= 1'b0; // [RULE13]
			end
			else if (pin.orig_btn)
			begin
				orig_ff <= 1'b1;
			end
		end
	end

	assign ans_mode_o  = !orig_ff; // [RULE13]
	assign orig_mode_o = orig_ff;

	// Answer-back trigger machine
	abr_ab_state_t        ab_ff;
	abr_ab_state_t        nxt_ab;
	logic                 call_cond;

	// Carrier seen while answering and on-line
	assign call_cond = pin.carrier_det && ans_mode_o && pin.on_line;

	// Next trigger state
	always_comb
	begin
		nxt_ab = ab_ff;
		case (ab_ff)
			AB_ARMED:
			begin
				// Fire only when the whole call condition holds
				if (call_cond && !ctl_rst)
				begin
					nxt_ab = AB_TRIP; // [RULE2]
				end
			end
			AB_TRIP:
			begin
				if (!call_cond)
				begin
					nxt_ab = AB_ARMED; // [RULE1]
				end
				else if (space_to_mark)
				begin
					nxt_ab = AB_SPENT; // [RULE3]
				end
			end
			AB_SPENT:
			begin
				// Re-arm for the next call
				if (!call_cond)
				begin
					nxt_ab = AB_ARMED; // [RULE4]
				end
			end
			default:
			begin
				nxt_ab = AB_ARMED;
			end
		endcase
		// Shared reset always re-arms
		if (ctl_rst)
		begin
			nxt_ab = AB_ARMED;
		end
	end

	// Trigger state register
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			ab_ff <= AB_ARMED;
		end
		else if (clk_en)
		begin
			ab_ff <= nxt_ab;
		end
	end

	// Trip drive and message start; manual key works anytime
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			trip_o             <= 1'b0;
			answerback_start_o <= 1'b0;
		end
		else if (clk_en)
		begin
			trip_o             <= (nxt_ab == AB_TRIP); // [RULE1] [RULE2] [RULE3]
			answerback_start_o <= (nxt_ab == AB_TRIP) || pin.manual_answerback_key; // [RULE1]
		end
	end

	// Interrupt events, one-cycle each
	logic                 trip_q;
	logic                 ctl_rst_q;
	logic                 expired_q;
	logic                 alarm_q;

	// Previous levels for edge events
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			trip_q    <= 1'b0;
			ctl_rst_q <= 1'b0;
			expired_q <= 1'b0;
			alarm_q   <= 1'b0;
		end
		else if (clk_en)
		begin
			trip_q    <= trip_o;
			ctl_rst_q <= ctl_rst;
			expired_q <= expired_ff;
			alarm_q   <= pin.paper_alarm;
		end
	end

	assign ev[EV_TRIP_ON]  = trip_o && !trip_q;
	assign ev[EV_TRIP_OFF] = !trip_o && trip_q;
	assign ev[EV_RESET]    = ctl_rst && !ctl_rst_q;
	assign ev[EV_EXPIRE]   = expired_ff && !expired_q;
	assign ev[EV_ALARM]    = pin.paper_alarm && !alarm_q;

	// Control and mask writes
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			paper_opt_ff <= CTRL_RST_PAPER;
			irq_msk_ff   <= IRQ_MSK_RST;
		end
		else if (clk_en && req_i.wr)
		begin
			if (req_i.addr == OFS_CTRL)
			begin
				paper_opt_ff <= req_i.wdata[CTRL_PAPER_OPT];
			end
			if (req_i.addr == OFS_IRQ_MSK)
			begin
				irq_msk_ff <= req_i.wdata[IRQ_W-1:0];
			end
		end
	end

	// Sticky status: write one clears, a new event wins
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			irq_st_ff <= '0;
		end
		else if (clk_en)
		begin
			if (req_i.wr && req_i.addr == OFS_IRQ_ST)
			begin
				irq_st_ff <= (irq_st_ff & ~req_i.wdata[IRQ_W-1:0]) | ev;
			end
			else
			begin
				irq_st_ff <= irq_st_ff | ev;
			end
		end
	end

	assign irq_o = |(irq_st_ff & irq_msk_ff);

	// Live status word
	always_comb
	begin
		stat_word                = '0;
		stat_word[STAT_TRIP]     = trip_o;
		stat_word[STAT_ARMED]    = (ab_ff == AB_ARMED);
		stat_word[STAT_ANS_MODE] = ans_mode_o;
		stat_word[STAT_ONLINE]   = pin.on_line;
		stat_word[STAT_CARRIER]  = pin.carrier_det;
		stat_word[STAT_RESET_N]  = ctl_reset_n_o;
		stat_word[STAT_EXPIRED]  = expired_ff;
		stat_word[STAT_ALARM]    = pin.paper_alarm;
	end

	// Read decode; unmapped offsets read zero
	always_comb
	begin
		nxt_rdata = '0;
		case (req_i.addr)
			OFS_CTRL:    nxt_rdata[CTRL_PAPER_OPT] = paper_opt_ff;
			OFS_STAT:    nxt_rdata = stat_word;
			OFS_IRQ_ST:  nxt_rdata[IRQ_W-1:0] = irq_st_ff;
			OFS_IRQ_MSK: nxt_rdata[IRQ_W-1:0] = irq_msk_ff;
			default:     nxt_rdata = '0;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			rdata_o <= '0;
		end
		else if (clk_en)
		begin
			rdata_o <= req_i.rd ? nxt_rdata : '0;
		end
	end

endmodule : abr_answerback_reset

/* dv/abr_far_end.sv */
// Far-side model: remote carrier and the tripped answer-back sender
module abr_far_end
(
	input  wire logic       sys_clk,
	input  wire logic       trip,
	input  wire logic       call,
	input  wire logic [7:0] lag,
	output logic            carrier,
	output logic            send_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Remote carrier follows the call request, one process per output
	initial
	begin
		carrier = 1'b0;
		forever
		begin
			@(posedge sys_clk);
			carrier <= call;
		end
	end
	// Line rests at mark; message after a prompt or slow lag
	initial
	begin
		send_data = 1'b1;
		forever
		begin
			@(posedge trip);
			repeat (lag) @(posedge sys_clk);
			send_data <= 1'b0;
			repeat (6) @(posedge sys_clk);
			send_data <= 1'b1;
		end
	end
endmodule : abr_far_end

/* dv/abr_properties.sv */
// Port-level checks for the answer-back and reset block
module abr_properties
	import abr_pkg::*;
#(
	parameter longint unsigned NOCARR_CYCLES = NOCARR_CYC
)
(
	input wire logic              sys_clk,
	input wire logic              rst_n,
	input wire logic              clk_en,
	input wire abr_pins_t         pins_i,
	input wire abr_req_t          req_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic              trip_o,
	input wire logic              answerback_start_o,
	input wire logic              ans_mode_o,
	input wire logic              orig_mode_o,
	input wire logic              ctl_reset_n_o,
	input wire logic              alarm_lamp_o,
	input wire logic              irq_o
);
	default clocking @(posedge sys_clk); endclocking
	// Frozen cycles are not judged: the pins move while the block stands still
	default disable iff (!rst_n || !clk_en);
	// Margin covers the filter and output register
	localparam longint unsigned FIRE = NOCARR_CYCLES + 64'd10;
	// Cycles on-line without carrier, saturating
	logic [15:0] nc_ff;
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			nc_ff <= 16'h0000;
		else if (!pins_i.on_line || pins_i.carrier_det)
			nc_ff <= 16'h0000;
		else if (nc_ff != 16'hFFFF)
			nc_ff <= nc_ff + 16'h0001;
	a_mode_pair:
		assert property ($rose(orig_mode_o) |-> ctl_reset_n_o && !ans_mode_o)
			else $error("orig set under reset");
	a_reset_answer:
		assert property (!ctl_reset_n_o [*2] |-> ans_mode_o) else $error("reset left orig");
	a_reset_no_trip:
		assert property (!ctl_reset_n_o [*2] |-> !trip_o) else $error("trip in reset");
	a_idle_no_trip:
		assert property ((!pins_i.carrier_det || !pins_i.on_line) [*8] |-> !trip_o)
			else $error("trip without call");
	a_mark_ends:
		assert property (trip_o && $rose(pins_i.send_data) |-> ##[1:8] !trip_o)
			else $error("mark did not end trip");
	a_stay_clear:
		assert property ($fell(trip_o) |=> !trip_o [*4]) else $error("trip re-fired");
	a_key_start:
		assert property (pins_i.manual_answerback_key [*8] |-> answerback_start_o)
			else $error("key ignored");
	a_btn_reset:
		assert property ((pins_i.eot_contact || pins_i.clear_btn) [*8] |-> !ctl_reset_n_o)
			else $error("no button reset");
	a_local_reset:
		assert property (pins_i.local_btn [*8] |-> !ctl_reset_n_o) else $error("no local reset");
	a_lamp_on:
		assert property (pins_i.paper_alarm [*8] |-> alarm_lamp_o) else $error("lamp dark");
	a_timer_fire:
		assert property (nc_ff > FIRE |-> !ctl_reset_n_o) else $error("timer silent");
	a_read_idle:
		assert property (!$past(req_i.rd) |-> rdata_o == 32'h0) else $error("stray rdata");
	c_trip: cover property ($rose(trip_o));
	c_key: cover property ($rose(answerback_start_o) && !trip_o);
	c_timer: cover property (nc_ff > FIRE);
endmodule : abr_properties

bind abr_answerback_reset abr_properties #(.NOCARR_CYCLES(NOCARR_CYCLES)) u_props (
	.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .pins_i(pins_i), .req_i(req_i),
	.rdata_o(rdata_o), .trip_o(trip_o), .answerback_start_o(answerback_start_o),
	.ans_mode_o(ans_mode_o), .orig_mode_o(orig_mode_o), .ctl_reset_n_o(ctl_reset_n_o),
	.alarm_lamp_o(alarm_lamp_o), .irq_o(irq_o));

/* dv/test_answerback_trigger_and_reset.sv */
// Self-checking bench for the answer-back trigger and reset block
module test_answerback_trigger_and_reset
	import abr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  b = 8'h00; // on_line down to manual key
	logic        call = 1'b0;
	logic [7:0]  lag = 8'h04;
	logic [7:0]  rnd = 8'h28;
	abr_req_t    req = '0;
	abr_pins_t   pins;
	logic        car, sd, trip, start, ans, orig, rstn, lamp, irq;
	logic [31:0] rdata, got;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          cyc = 0;
	logic        en = 1'b1;
	// Register model: control and mask as software wrote them
	int unsigned mdl_ctrl = 0;
	int unsigned mdl_msk = 0;
	assign pins = abr_pins_t'({car, sd, b});
	initial forever #2.5 sys_clk = ~sys_clk;
	// Short power-on and no-carrier counts keep the run brief
	abr_answerback_reset #(.POR_CYCLES(20), .NOCARR_CYCLES(50)) DUT (
		.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(en), .pins_i(pins), .req_i(req),
		.rdata_o(rdata), .trip_o(trip), .answerback_start_o(start), .ans_mode_o(ans),
		.orig_mode_o(orig), .ctl_reset_n_o(rstn), .alarm_lamp_o(lamp), .irq_o(irq));
	abr_far_end u_far (.sys_clk(sys_clk), .trip(trip), .call(call), .lag(lag),
		.carrier(car), .send_data(sd));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic give_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	// Compare one result; four-state so unknowns fail
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// Wait for a level under a bound, then compare
	task automatic await(ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++)
			tick(1);
		cmp(s, v);
	endtask : await
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		req.wr <= 1'b0;
		// Model keeps only the defined fields
		if (a == OFS_CTRL)
			mdl_ctrl = d & (32'h1 << CTRL_PAPER_OPT);
		if (a == OFS_IRQ_MSK)
			mdl_msk = d & ((32'h1 << IRQ_W) - 32'h1);
	endtask : wr
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		#1 got = rdata;
	endtask : rd
	// Read one register and hold it against the model
	task automatic cmp_reg(input logic [3:0] a);
		logic [31:0] e;
		e = 32'h0;
		if (a == OFS_CTRL)
			e = mdl_ctrl;
		if (a == OFS_IRQ_MSK)
			e = mdl_msk;
		rd(a);
		cmp(got, e);
	endtask : cmp_reg
	// Hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial
	begin
		tick(10);
		rst_n <= 1'b1;
		tick(15);
		cmp(rstn, 1'b0);
		await(rstn, 1'b1, 40);
		cmp({ans, orig}, 2'b10);
		cmp_reg(OFS_CTRL);
		rd(OFS_STAT);
		cmp(got, (32'h1 << STAT_ARMED) | (32'h1 << STAT_ANS_MODE) | (32'h1 << STAT_RESET_N));
		cmp_reg(4'h2);
		rnd = lfsr(rnd);
		wr(OFS_IRQ_MSK, {24'h0, rnd});
		cmp_reg(OFS_IRQ_MSK);
		wr(OFS_IRQ_MSK, 32'h0);
		wr(OFS_IRQ_ST, 32'h1F);
		// Answered call trips once, message ends it
		rnd = lfsr(rnd);
		lag <= {4'h0, rnd[3:0]};
		call <= 1'b1;
		b[7] <= 1'b1;
		await(trip, 1'b1, 12);
		cmp(start, 1'b1);
		await(trip, 1'b0, 40);
		tick(20);
		cmp(trip, 1'b0);
		rd(OFS_IRQ_ST);
		cmp(got & 32'h3, 32'h3);
		cmp(irq, 1'b0);
		wr(OFS_IRQ_MSK, 32'h2);
		tick(2);
		cmp(irq, 1'b1);
		wr(OFS_IRQ_ST, 32'h2);
		tick(2);
		cmp(irq, 1'b0);
		// Carrier lost after expiry resets, then re-arms
		tick(30);
		call <= 1'b0;
		await(rstn, 1'b0, 12);
		call <= 1'b1;
		await(rstn, 1'b1, 12);
		await(trip, 1'b1, 20);
		await(trip, 1'b0, 40);
		b[7] <= 1'b0;
		call <= 1'b0;
		tick(10);
		// Originate mode: no trip, key still starts
		b[5] <= 1'b1;
		tick(8);
		b[5] <= 1'b0;
		tick(4);
		cmp({ans, orig}, 2'b01);
		call <= 1'b1;
		b[7] <= 1'b1;
		tick(30);
		cmp(trip, 1'b0);
		b[0] <= 1'b1;
		tick(9);
		cmp(start, 1'b1);
		b[0] <= 1'b0;
		b[4] <= 1'b1;
		await(rstn, 1'b0, 10);
		tick(2);
		cmp({ans, orig}, 2'b10);
		b[4] <= 1'b0;
		await(trip, 1'b1, 30);
		await(trip, 1'b0, 40);
		b[7] <= 1'b0;
		call <= 1'b0;
		tick(10);
		// Alarm, end of transmission, local, clear
		for (int i = 1; i <= 4; i++)
		begin
			b[i] <= 1'b1;
			await(rstn, 1'b0, 10);
			tick(4);
			if (i == 1)
				cmp(lamp, 1'b1);
			b[i] <= 1'b0;
			await(rstn, 1'b1, 10);
		end
		// Clock enable low freezes all, even a held clear
		en <= 1'b0;
		b[4] <= 1'b1;
		tick(12);
		cmp(rstn, 1'b1);
		en <= 1'b1;
		await(rstn, 1'b0, 10);
		b[4] <= 1'b0;
		await(rstn, 1'b1, 10);
		// Answer button alone leaves originate mode
		b[5] <= 1'b1;
		tick(8);
		cmp({ans, orig}, 2'b01);
		b[5] <= 1'b0;
		b[6] <= 1'b1;
		tick(8);
		cmp({ans, orig}, 2'b10);
		b[6] <= 1'b0;
		wr(OFS_CTRL, 32'h1);
		cmp_reg(OFS_CTRL);
		b[1] <= 1'b1;
		tick(12);
		cmp({rstn, lamp}, 2'b11);
		b[1] <= 1'b0;
		// Let the alarm leave the filter before the option goes
		tick(6);
		wr(OFS_CTRL, 32'h0);
		// No-carrier timer fires, clears off-line
		b[7] <= 1'b1;
		tick(40);
		cmp(rstn, 1'b1);
		await(rstn, 1'b0, 30);
		tick(8);
		b[7] <= 1'b0;
		await(rstn, 1'b1, 12);
		b[7] <= 1'b1;
		tick(40);
		cmp(rstn, 1'b1);
		b[7] <= 1'b0;
		tick(10);
		give_verdict();
	end
endmodule : test_answerback_trigger_and_reset
